// file: rtl/epr_consts.vh
`ifndef EPR_CONSTS_VH
`define EPR_CONSTS_VH

// exception numbers of the fixed and system exceptions
`define EPR_NUM_RESET 1
`define EPR_NUM_NMI 2
`define EPR_NUM_HARD 3
`define EPR_NUM_MEM 4
`define EPR_NUM_BUS 5
`define EPR_NUM_USAGE 6
`define EPR_NUM_SVC 11
`define EPR_NUM_DEBUG 12
`define EPR_NUM_PENDSRV 14
`define EPR_NUM_TIMER 15
`define EPR_NUM_EXT_BASE 16
// first system exception whose priority comes from the handler fields
`define EPR_NUM_SYS_BASE 4
// number of system handler priority slots (numbers 4 to 15)
`define EPR_SYS_SLOTS 12

// exception number width and priority key width
`define EPR_NUM_W 8
`define EPR_KEY_W 9

// implemented priority bits and their position in the 8-bit field
`define EPR_PRIO_BITS 3
`define EPR_PRIO_LSB 5
`define EPR_PRIO_PAD 5'h00

// fixed priorities -3, -2, -1 as ranks below every configurable key
`define EPR_KEY_RESET 9'h000
`define EPR_KEY_NMI 9'h001
`define EPR_KEY_HARD 9'h002
// configurable keys carry this flag in their top bit
`define EPR_KEY_CFG 1'b1
// execution priority when nothing is active (thread level)
`define EPR_KEY_IDLE 9'h1ff

// reset value of the priority split selector
`define EPR_SPLIT_RST 3'h0

`endif

// file: rtl/epr_pin_sync.v
// two-flop synchroniser for asynchronous request pins
module epr_pin_sync #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] pin_async,
    output wire [WIDTH-1:0] pin_sync
);
    reg [WIDTH-1:0] meta_q; // first stage, read only by the second
    reg [WIDTH-1:0] sync_q; // second stage, safe to use

    // both stages clear to zero on reset
    always @(posedge core_clk) begin
        if (sys_rst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= pin_async;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;
endmodule // epr_pin_sync

// file: rtl/epr_min_pick.v
`include "epr_consts.vh"
// picks the requesting entry with the smallest key; ties go to the
// smaller index because only a strictly smaller key replaces the pick
module epr_min_pick #(
    parameter N = 48
) (
    input wire [N-1:0] req,
    input wire [N*`EPR_KEY_W-1:0] keys,
    output reg found,
    output reg [`EPR_NUM_W-1:0] idx,
    output reg [`EPR_KEY_W-1:0] key
);
    integer i;

    // linear scan from exception number 0 upward
    always @* begin
        found = 1'b0;
        idx = {`EPR_NUM_W{1'b0}};
        key = `EPR_KEY_IDLE;
        for (i = 0; i < N; i = i + 1) begin
            if (req[i] && (!found || keys[i*`EPR_KEY_W +: `EPR_KEY_W] < key))
            begin
                found = 1'b1;
                idx = i[`EPR_NUM_W-1:0];
                key = keys[i*`EPR_KEY_W +: `EPR_KEY_W];
            end
        end
    end
endmodule // epr_min_pick

// file: rtl/epr_exception_resolver.v
`include "epr_consts.vh"
// Function
// - service only the highest priority pending request
// - reset -3, nmi -2, hard fault -1 fixed
// - disabled memory, bus, usage fault become hard
// - fixed exception numbers, external from sixteen up
// - unsigned priority, lower value is more urgent
// - priority fields hold three significant bits
// - bits seven to five used, rest zero
// - external and system handler priority sources
// - split selector divides pre-emption and sub-priority
// - compare pre-emption, then sub, then number
// - selector s gives pre-emption bits seven..s+1
// - unactivatable or disabled fault raises hard fault
// - never-executable fetch or fault region access trap
// - memory management only from never-executable fetches
// - signal state save on take, restore on return
module epr_exception_resolver #(
    parameter NUM_EXT = 32
) (
    input wire core_clk,
    input wire sys_rst,
    input wire reset_pin_n,
    input wire wdt_reset_req,
    input wire software_system_reset_request,
    input wire nmi_pin_n,
    input wire wdt_nmi_req,
    input wire never_executable_region,
    input wire fault_region_access,
    input wire usage_fault_event,
    input wire mem_manage_enable,
    input wire bus_fault_enable,
    input wire usage_fault_enable,
    input wire supervisor_call_exception,
    input wire debug_monitor_req,
    input wire pendable_service_set,
    input wire pendable_service_clear,
    input wire system_timer_exception,
    input wire [NUM_EXT-1:0] ext_irq_pins,
    input wire [NUM_EXT-1:0] ext_irq_enable,
    input wire [`EPR_SYS_SLOTS*`EPR_PRIO_BITS-1:0] sys_handler_prio,
    input wire [NUM_EXT*`EPR_PRIO_BITS-1:0] ext_irq_prio,
    input wire [2:0] priority_split_sel,
    input wire cpu_take_ack,
    input wire cpu_exc_return,
    input wire [`EPR_NUM_W-1:0] cpu_return_num,
    output reg exc_take_req,
    output reg [`EPR_NUM_W-1:0] exc_take_num,
    output reg stack_save,
    output reg stack_restore,
    output reg active_valid,
    output reg [`EPR_NUM_W-1:0] active_num,
    output reg [`EPR_KEY_W-1:0] exec_prio,
    output reg [`EPR_NUM_EXT_BASE+NUM_EXT-1:0] pending_status
);
    localparam N = `EPR_NUM_EXT_BASE + NUM_EXT;

    // pending and active flags, one per exception number
    reg [N-1:0] pend_q;
    reg [N-1:0] pend_d;
    reg [N-1:0] act_q;
    reg [N-1:0] act_d;
    // edge detect history of the synchronised reset and nmi pins
    reg rst_pin_hist_q;
    reg nmi_pin_hist_q;
    // combinational helpers
    reg [N-1:0] set_vec;
    reg [N-1:0] clr_vec;
    reg [N-1:0] take_vec;
    reg [N-1:0] ret_vec;
    reg [N*`EPR_KEY_W-1:0] keys;
    reg [N-1:0] ext_level;
    reg esc_mem;
    reg esc_bus;
    reg esc_usage;
    integer i;

    // synchronised pins: ext irqs, nmi pin, reset pin
    wire [NUM_EXT+1:0] pins_s;
    wire rst_pin_s;
    wire nmi_pin_s;
    // winner among pending and most urgent active entry
    wire win_found;
    wire [`EPR_NUM_W-1:0] win_idx;
    wire [`EPR_KEY_W-1:0] win_key;
    wire act_found;
    wire [`EPR_NUM_W-1:0] act_idx;
    wire [`EPR_KEY_W-1:0] act_key;
    wire take_now;
    wire [`EPR_KEY_W-1:0] exec_d;

    // true for numbers that exist; reserved and zero never hold state
    // a flag on a reserved number would offer a handler that is not there
    function valid_num;
        input integer n;
        begin
            valid_num = (n >= `EPR_NUM_RESET) &&
                !(n >= 7 && n <= 10) && (n != 13);
        end
    endfunction

    // keeps only the pre-emption part of a key for the given split
    // fixed keys pass unchanged, they have no sub-priority part
    function [`EPR_KEY_W-1:0] group_key;
        input [`EPR_KEY_W-1:0] key;
        input [2:0] sel;
        reg [7:0] mask;
        begin
            mask = 8'hfe << sel;
            if (key[`EPR_KEY_W-1] == `EPR_KEY_CFG)
                group_key = {key[`EPR_KEY_W-1], key[7:0] & mask};
            else
                group_key = key;
        end
    endfunction

    // pins pass two flops before any logic sees them; the two low pins
    // go in inverted so that the cleared synchroniser reads as their
    // idle high level and no false reset edge follows a reset
    epr_pin_sync #(
        .WIDTH(NUM_EXT + 2)
    ) u_pin_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_async({ext_irq_pins, ~nmi_pin_n, ~reset_pin_n}),
        .pin_sync(pins_s)
    );
    // back to pin polarity: high while the pin is high
    assign rst_pin_s = ~pins_s[0];
    assign nmi_pin_s = ~pins_s[1];

    // builds the sort key of every exception number
    // fixed exceptions get keys with the top bit clear, so they rank
    // above every configurable key; number zero keeps all ones
    always @* begin
        keys = {N*`EPR_KEY_W{1'b1}};
        for (i = 0; i < N; i = i + 1) begin
            if (i >= `EPR_NUM_EXT_BASE)
                keys[i*`EPR_KEY_W +: `EPR_KEY_W] = {`EPR_KEY_CFG,
                    ext_irq_prio[(i-`EPR_NUM_EXT_BASE)*`EPR_PRIO_BITS +:
                    `EPR_PRIO_BITS], `EPR_PRIO_PAD};
            else if (i >= `EPR_NUM_SYS_BASE)
                keys[i*`EPR_KEY_W +: `EPR_KEY_W] = {`EPR_KEY_CFG,
                    sys_handler_prio[(i-`EPR_NUM_SYS_BASE)*`EPR_PRIO_BITS +:
                    `EPR_PRIO_BITS], `EPR_PRIO_PAD};
        end
        keys[`EPR_NUM_RESET*`EPR_KEY_W +: `EPR_KEY_W] = `EPR_KEY_RESET;
        keys[`EPR_NUM_NMI*`EPR_KEY_W +: `EPR_KEY_W] = `EPR_KEY_NMI;
        keys[`EPR_NUM_HARD*`EPR_KEY_W +: `EPR_KEY_W] = `EPR_KEY_HARD;
    end

    // a fault escalates when disabled or unable to pre-empt now
    // the test uses the registered execution priority, so a fault in the
    // same cycle as a take is judged against the older level; this
    // costs one cycle of accuracy and keeps the path short
    always @* begin
        esc_mem = !mem_manage_enable || group_key(keys[`EPR_NUM_MEM*
            `EPR_KEY_W +: `EPR_KEY_W], priority_split_sel) >= exec_prio;
        esc_bus = !bus_fault_enable || group_key(keys[`EPR_NUM_BUS*
            `EPR_KEY_W +: `EPR_KEY_W], priority_split_sel) >= exec_prio;
        esc_usage = !usage_fault_enable || group_key(keys[`EPR_NUM_USAGE*
            `EPR_KEY_W +: `EPR_KEY_W], priority_split_sel) >= exec_prio;
    end

    // request sources that set pending flags this cycle
    always @* begin
        set_vec = {N{1'b0}};
        ext_level = {N{1'b0}};
        // pin edges: reset on a rising edge, nmi on a falling edge
        // numbers by source
        set_vec[`EPR_NUM_RESET] = wdt_reset_req ||
            software_system_reset_request || (rst_pin_s && !rst_pin_hist_q);
        set_vec[`EPR_NUM_NMI] = wdt_nmi_req || (!nmi_pin_s && nmi_pin_hist_q);
        set_vec[`EPR_NUM_MEM] = never_executable_region && !esc_mem;
        set_vec[`EPR_NUM_BUS] = fault_region_access && !esc_bus;
        set_vec[`EPR_NUM_USAGE] = usage_fault_event && !esc_usage;
        set_vec[`EPR_NUM_HARD] = (never_executable_region && esc_mem) ||
            (fault_region_access && esc_bus) ||
            (usage_fault_event && esc_usage);
        set_vec[`EPR_NUM_SVC] = supervisor_call_exception;
        set_vec[`EPR_NUM_DEBUG] = debug_monitor_req;
        set_vec[`EPR_NUM_PENDSRV] = pendable_service_set;
        set_vec[`EPR_NUM_TIMER] = system_timer_exception;
        // level requests from enabled external pins
        ext_level[N-1:`EPR_NUM_EXT_BASE] = pins_s[NUM_EXT+1:2] &
            ext_irq_enable;
        set_vec = set_vec | ext_level;
    end

    // take and return events as one-hot vectors
    // an acknowledge only counts while a request is shown; the number
    // taken is whatever the output showed in that cycle, so a winner
    // that changed late is still taken consistently
    assign take_now = cpu_take_ack && exc_take_req;
    always @* begin
        take_vec = {N{1'b0}};
        ret_vec = {N{1'b0}};
        clr_vec = {N{1'b0}};
        for (i = 0; i < N; i = i + 1) begin
            take_vec[i] = take_now && (exc_take_num == i);
            ret_vec[i] = cpu_exc_return && (cpu_return_num == i);
        end
        clr_vec = take_vec;
        clr_vec[`EPR_NUM_PENDSRV] = take_vec[`EPR_NUM_PENDSRV] ||
            pendable_service_clear;
    end

    // next pending and active state; a set beats a clear
    // a request and a take in the same cycle leave the flag set, so an
    // event that lands while its handler is being entered is not lost
    always @* begin
        pend_d = (pend_q & ~clr_vec) | set_vec;
        act_d = (act_q & ~ret_vec) | take_vec;
        for (i = 0; i < N; i = i + 1) begin
            if (!valid_num(i)) begin
                pend_d[i] = 1'b0;
                act_d[i] = 1'b0;
            end
        end
    end

    // both pickers see the next-state vectors so that the outputs below
    // describe the state that the flags will hold after this edge
    // pick highest pending
    epr_min_pick #(
        .N(N)
    ) u_pend_pick (
        .req(pend_d),
        .keys(keys),
        .found(win_found),
        .idx(win_idx),
        .key(win_key)
    );

    // most urgent active entry sets the execution priority
    epr_min_pick #(
        .N(N)
    ) u_act_pick (
        .req(act_d),
        .keys(keys),
        .found(act_found),
        .idx(act_idx),
        .key(act_key)
    );

    // no active handler means thread level, below every key
    // split into pre-emption part
    assign exec_d = act_found ? group_key(act_key, priority_split_sel) :
        `EPR_KEY_IDLE;

    // state registers and registered outputs
    // every output is a flop; exc_take_req compares the winner's
    // pre-emption part with the execution priority after this edge
    always @(posedge core_clk) begin
        if (sys_rst) begin
            // the reset exception is pending out of reset
            pend_q <= {{(N-2){1'b0}}, 2'b10};
            act_q <= {N{1'b0}};
            // history starts at the idle high level of both pins
            rst_pin_hist_q <= 1'b1;
            nmi_pin_hist_q <= 1'b1;
            exc_take_req <= 1'b0;
            exc_take_num <= {`EPR_NUM_W{1'b0}};
            stack_save <= 1'b0;
            stack_restore <= 1'b0;
            active_valid <= 1'b0;
            active_num <= {`EPR_NUM_W{1'b0}};
            exec_prio <= `EPR_KEY_IDLE;
            pending_status <= {N{1'b0}};
        end else begin
            pend_q <= pend_d;
            act_q <= act_d;
            rst_pin_hist_q <= rst_pin_s;
            nmi_pin_hist_q <= nmi_pin_s;
            exc_take_req <= win_found &&
                (group_key(win_key, priority_split_sel) < exec_d);
            exc_take_num <= win_idx;
            stack_save <= take_now;
            stack_restore <= cpu_exc_return && (|(act_q & ret_vec));
            active_valid <= act_found;
            active_num <= act_idx;
            exec_prio <= exec_d;
            pending_status <= pend_d;
        end
    end
endmodule // epr_exception_resolver

// file: verification/epr_exception_resolver_chk.sv
`include "epr_consts.vh"
// watches the resolver's ports for handshake and pending-state slips
module epr_exception_resolver_chk #(
    parameter NUM_EXT = 32
) (
    input wire core_clk,
    input wire sys_rst,
    input wire usage_fault_event,
    input wire usage_fault_enable,
    input wire supervisor_call_exception,
    input wire cpu_take_ack,
    input wire cpu_exc_return,
    input wire [`EPR_NUM_W-1:0] cpu_return_num,
    input wire exc_take_req,
    input wire [`EPR_NUM_W-1:0] exc_take_num,
    input wire stack_save,
    input wire stack_restore,
    input wire active_valid,
    input wire [`EPR_NUM_W-1:0] active_num,
    input wire [`EPR_KEY_W-1:0] exec_prio,
    input wire [`EPR_NUM_EXT_BASE+NUM_EXT-1:0] pending_status
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_save; cpu_take_ack && exc_take_req |=> stack_save; endproperty
    a_save: assert property (p_save) else $error("no save pulse");
    property p_save_src;
        stack_save |-> $past(cpu_take_ack && exc_take_req);
    endproperty
    a_save_src: assert property (p_save_src) else $error("stray save");
    property p_rest; stack_restore |-> $past(cpu_exc_return); endproperty
    a_rest: assert property (p_rest) else $error("stray restore");
    property p_rest_due;
        cpu_exc_return && active_valid && cpu_return_num == active_num
            |=> stack_restore;
    endproperty
    a_rest_due: assert property (p_rest_due) else $error("no restore");
    property p_resv;
        !(|{pending_status[13], pending_status[10:7], pending_status[0]});
    endproperty
    a_resv: assert property (p_resv) else $error("reserved pending");
    property p_act_resv;
        active_valid |-> !(active_num inside {0, 7, 8, 9, 10, 13});
    endproperty
    a_act_resv: assert property (p_act_resv) else $error("resv active");
    property p_req; exc_take_req |-> pending_status[exc_take_num]; endproperty
    a_req: assert property (p_req) else $error("winner not pending");
    property p_svc; supervisor_call_exception |=> pending_status[11]; endproperty
    a_svc: assert property (p_svc) else $error("call not pended");
    property p_esc;
        usage_fault_event && !usage_fault_enable |=> pending_status[3];
    endproperty
    a_esc: assert property (p_esc) else $error("no escalation");
    property p_rst_win;
        pending_status[1] && exec_prio != 9'h000
            |-> exc_take_req && exc_take_num == 1;
    endproperty
    a_rst_win: assert property (p_rst_win) else $error("reset lost");
    c_save: cover property (stack_save);
    c_rest: cover property (stack_restore);
    c_hard: cover property (pending_status[3]);
endmodule // epr_exception_resolver_chk

bind epr_exception_resolver epr_exception_resolver_chk #(.NUM_EXT(NUM_EXT))
    epr_chk_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .usage_fault_event(usage_fault_event),
    .usage_fault_enable(usage_fault_enable),
    .supervisor_call_exception(supervisor_call_exception),
    .cpu_take_ack(cpu_take_ack), .cpu_exc_return(cpu_exc_return),
    .cpu_return_num(cpu_return_num),
    .exc_take_req(exc_take_req), .exc_take_num(exc_take_num),
    .stack_save(stack_save), .stack_restore(stack_restore),
    .active_valid(active_valid), .active_num(active_num),
    .exec_prio(exec_prio), .pending_status(pending_status));

// file: verification/epr_cpu_model.sv
// pipeline stand-in: takes offered exceptions and returns active ones
module epr_cpu_model (
    input wire core_clk,
    input wire sys_rst,
    input wire ack_en,
    input wire ret_en,
    input wire slow,
    input wire exc_take_req,
    input wire active_valid,
    input wire [7:0] active_num,
    output reg cpu_take_ack,
    output reg cpu_exc_return,
    output reg [7:0] cpu_return_num
);
    timeunit 1ns;
    timeprecision 1ps;
    reg tog_q = 1'b0; // paces the slow mode to every other cycle
    wire idle = !cpu_take_ack && !cpu_exc_return && (!slow || tog_q);
    wire go_ack = !sys_rst && ack_en && exc_take_req && idle;
    wire go_ret = !sys_rst && ret_en && active_valid && !exc_take_req && idle;
    // one-cycle pulses; return number scrambles when not returning
    always @(posedge core_clk) begin
        tog_q <= ~tog_q;
        if (sys_rst) begin
            cpu_take_ack <= 1'b0;
            cpu_exc_return <= 1'b0;
            cpu_return_num <= 8'h00;
        end else begin
            cpu_take_ack <= go_ack;
            cpu_exc_return <= go_ret;
            cpu_return_num <= go_ret ? active_num : ~cpu_return_num;
        end
    end
endmodule // epr_cpu_model

// file: verification/exception_priority_resolver_tb_top.sv
module exception_priority_resolver_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg core_clk = 0, sys_rst = 1, rpin_n = 1, nmi_n = 1, ack_en = 0;
    reg ret_en = 0, slow = 0, nx = 0, fr = 0, ue = 0, svc = 0, dbg = 0;
    reg pss = 0, tmr = 0;
    reg [2:0] en3 = 0, sel = 0;
    reg [3:0] pins = 0, pen = 0;
    reg [35:0] shp = 0;
    reg [11:0] ep = 0;
    wire ack, ret, req, save, rest, av;
    wire [7:0] rnum, num, anum;
    wire [8:0] xp;
    wire [19:0] pend;
    integer err_total = 0, n_compared = 0, cyc = 0, it, i;
    reg [19:0] p;
    reg [7:0] w, w2;
    always #4 core_clk = ~core_clk;
    epr_exception_resolver #(.NUM_EXT(4)) epr_exception_resolver_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .reset_pin_n(rpin_n),
        .wdt_reset_req(1'b0), .software_system_reset_request(1'b0),
        .nmi_pin_n(nmi_n), .wdt_nmi_req(1'b0), .never_executable_region(nx),
        .fault_region_access(fr), .usage_fault_event(ue),
        .mem_manage_enable(en3[0]), .bus_fault_enable(en3[1]),
        .usage_fault_enable(en3[2]), .supervisor_call_exception(svc),
        .debug_monitor_req(dbg), .pendable_service_set(pss),
        .pendable_service_clear(1'b0), .system_timer_exception(tmr),
        .ext_irq_pins(pins), .ext_irq_enable(pen), .sys_handler_prio(shp),
        .ext_irq_prio(ep), .priority_split_sel(sel), .cpu_take_ack(ack),
        .cpu_exc_return(ret), .cpu_return_num(rnum), .exc_take_req(req),
        .exc_take_num(num), .stack_save(save), .stack_restore(rest),
        .active_valid(av), .active_num(anum), .exec_prio(xp),
        .pending_status(pend));
    epr_cpu_model epr_cpu_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .ack_en(ack_en), .ret_en(ret_en), .slow(slow), .exc_take_req(req),
        .active_valid(av), .active_num(anum), .cpu_take_ack(ack),
        .cpu_exc_return(ret), .cpu_return_num(rnum));
    // priority field of a configurable exception, top bits of eight
    function automatic [7:0] pri(input integer n);
        pri = {n < 16 ? shp[3*(n-4)+:3] : ep[3*(n-16)+:3], 5'h00};
    endfunction
    // pre-emption part under the current split selector
    function automatic [7:0] grp(input integer n);
        grp = pri(n) & (8'hff << (sel + 1));
    endfunction
    // smallest priority wins, then smallest number
    function automatic [7:0] best(input [19:0] m);
        integer n;
        best = 0;
        for (n = 19; n >= 11; n = n - 1)
            if (m[n] && (best == 0 || pri(n) <= pri(best))) best = n;
    endfunction
    task step; @(posedge core_clk); #1; endtask
    task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // let the pipeline take and return everything, then expect quiet
    task drain;
        {pins, ack_en, ret_en, slow} = {4'h0, 2'b11, 1'($urandom)};
        repeat (40) step;
        {ack_en, ret_en} = 0;
        repeat (2) step;
        chk("drained", 0, {av, pend});
    endtask
    // bounded run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            results;
        end
    end
    initial begin
        void'($urandom(31529));
        repeat (12) @(posedge core_clk);
        #1 sys_rst = 0;
        step;
        chk("reset pend", 3'h7, {pend[1], num == 1, req});
        chk("exec idle", 9'h1ff, xp);
        drain;
        for (i = 0; i < 3; i++) begin
            en3 = $urandom;
            {ue, fr, nx} = 3'b1 << i;
            step;
            {ue, fr, nx} = 0;
            chk("fault own", en3[i], pend[4+i]);
            chk("fault hard", !en3[i], pend[3]);
            drain;
        end
        nmi_n = 0;
        repeat (4) step;
        chk("nmi", 2, num);
        nmi_n = 1;
        drain;
        for (it = 0; it < 24; it++) begin
            // pen stands in for the enables set by software
            {shp, ep, sel, pen} = {$urandom, $urandom, $urandom};
            {svc, dbg, pss, tmr, pins} = $urandom | (it < 8 ? 8'hf0 : 8'h00);
            p = {pins & pen, tmr, pss, 1'b0, dbg, svc, 11'h000};
            step;
            {svc, dbg, pss, tmr, pins} = 0;
            repeat (4) step;
            w = best(p);
            chk("pending", p, pend);
            chk("winner", {w != 0, w}, {req, num});
            if (w != 0) begin
                ack_en = 1;
                step;
                // slow pacing may hold the acknowledge back one cycle
                if (ack !== 1'b1) step;
                ack_en = 0;
                step;
                chk("taken", {1'b1, w}, {save, anum});
                // fresh priorities while w is active make pre-emption live
                {shp, ep, sel} = {$urandom, $urandom};
                w2 = best(p & ~(20'h1 << w));
                step;
                chk("preempt", w2 != 0 && grp(w2) < grp(w), req);
                if (req === 1'b1) chk("next", w2, num);
            end
            drain;
        end
        results;
    end
endmodule // exception_priority_resolver_tb_top
